// File: rtl/led_sink_pkg.sv
package led_sink_pkg;
  // Register offsets
  localparam logic [7:0] CTRL_BASE_ADDR = 8'h06;
  localparam logic [7:0] CTRL_LAST_ADDR = 8'h0f;
  localparam logic [7:0] BRIGHT_BASE_ADDR = 8'h16;
  localparam logic [7:0] BRIGHT_LAST_ADDR = 8'h1f;
  localparam logic [7:0] CHIP_CONFIG_ADDR = 8'h00;
  localparam logic [7:0] POWER_SAVE_ADDR = 8'h36;
  localparam logic [7:0] SOFT_RESET_ADDR = 8'h3d;
  // Field positions
  localparam int SUPPLY_BIT = 6;
  localparam int CURVE_BIT = 5;
  localparam int RANGE_LSB = 3;
  localparam int CHIP_RUN_BIT = 6;
  localparam int BOOST_EN_BIT = 0;
  localparam int LIGHT_IN_BIT = 1;
  localparam int POWER_SAVE_BIT = 5;
  // Reset values
  localparam logic [7:0] CTRL_RESET = 8'h00;
  localparam logic [7:0] BRIGHT_RESET = 8'h00;
  localparam logic [7:0] CONFIG_RESET = 8'h00;
  localparam logic [7:0] POWER_SAVE_RESET = 8'h00;
  // Timing
  localparam int CLK_MHZ = 100;
  localparam int MEM_INIT_US = 10;
  localparam int MEM_INIT_CYCLES = MEM_INIT_US * CLK_MHZ;
  localparam int STARTUP_US = 5;
  localparam int STARTUP_CYCLES = STARTUP_US * CLK_MHZ;
  localparam int SOFT_START_US = 20;
  localparam int SOFT_START_CYCLES = SOFT_START_US * CLK_MHZ;
  localparam int NUM_CH = 10;
  typedef enum logic [2:0] {
    ST_RESET, ST_STANDBY, ST_MEMINIT, ST_STARTUP, ST_BOOST,
    ST_NORMAL, ST_POWERSAVE
  } mode_t;
endpackage

// File: rtl/led_sink_mode_control.sv
`timescale 1ns/1ps
`default_nettype none
// Functional notes
// - Any write to reset register reloads all defaults, then standby.
// - Power-on reset holds reset; on release go to standby.
// - Chip run bit reads zero after every reset.
// - Standby disables outputs; registers writable and effective at startup.
// - Enable pin high triggers memory initialisation before operation.
// - Chip run bit set launches internal startup sequence.
// - Thermal shutdown disables operation; stay in startup until clear.
// - Boost soft-start from startup end or normal when boost enabled.
// - All sinks forced off during boost soft-start.
// - Normal mode accepts any write order, any bits per write.
// - Power-save bit set enters power-save, analogue off while idle.
// - Supply bit zero selects boost output, one selects external supply.
// - Supply selection never enables boost; only boost bit does.
// - Output ten configured as light input never sinks current.
// - Full-scale bits select 3, 6, 12.5 or 25.5 mA.
// - Code zero is zero; linear current is code/255 of full scale.
// - Control bit five one selects logarithmic, zero linear curve.
// - Curve applies to engine and direct brightness alike.
// - Logarithmic curve uses 12-bit internal resolution.
// - Log minimum step 0.78 uA at code 00, 6.25 uA at 11.
// - Enable pin low holds device disabled and reset.
// - Engine brightness overrides direct brightness when engine drives.
module led_sink_mode_control #(
  parameter int MEM_INIT_CYC = led_sink_pkg::MEM_INIT_CYCLES,
  parameter int STARTUP_CYC = led_sink_pkg::STARTUP_CYCLES,
  parameter int SOFT_START_CYC = led_sink_pkg::SOFT_START_CYCLES
) (
  // Clock and reset
  input wire logic CORE_CLK,
  input wire logic RESET,
  // Pins and analogue status
  input wire logic EN_PIN,
  input wire logic POR_ACTIVE,
  input wire logic THERMAL_SHUTDOWN,
  input wire logic DEVICE_IDLE,
  // Register write/read port from serial interface
  input wire logic REG_WR,
  input wire logic REG_RD,
  input wire logic [7:0] REG_ADDR,
  input wire logic [7:0] REG_WDATA,
  output logic [7:0] REG_RDATA,
  // Lighting engine brightness
  input wire logic [9:0] ENGINE_ACTIVE,
  input wire logic [79:0] ENGINE_BRIGHT,
  // Analogue controls and status
  output logic BOOST_ON,
  output logic ANALOG_ON,
  output logic POWER_SAVE_ON,
  output logic MEM_INIT_BUSY,
  output logic [2:0] MODE,
  output logic [9:0] SINK_ON,
  output logic [9:0] SUPPLY_EXT,
  output logic [19:0] RANGE_SEL,
  output logic [119:0] SINK_CODE
);
  localparam int CW = 16;

  logic en_s1_ff, en_s2_ff, en_s3_ff, en_ff;
  logic por_s1_ff, por_s2_ff, por_s3_ff, por_ff;
  logic hot_s1_ff, hot_s2_ff, hot_s3_ff, hot_ff;
  logic soft_rst_ff;
  logic [7:0] ctrl_ff [10];
  logic [7:0] bright_ff [10];
  logic [7:0] config_ff;
  logic [7:0] psave_ff;
  led_sink_pkg::mode_t mode_ff, nxt_mode;
  logic [CW-1:0] cnt_ff, nxt_cnt;
  logic wr_reset;
  logic held_rst;

  // Pin synchronisers: accept change once stages two and three agree
  always_ff @(posedge CORE_CLK or posedge RESET) begin
    if (RESET) begin
      en_s1_ff <= 1'b0;
      en_s2_ff <= 1'b0;
      en_s3_ff <= 1'b0;
      en_ff <= 1'b0;
      por_s1_ff <= 1'b1;
      por_s2_ff <= 1'b1;
      por_s3_ff <= 1'b1;
      por_ff <= 1'b1;
      hot_s1_ff <= 1'b0;
      hot_s2_ff <= 1'b0;
      hot_s3_ff <= 1'b0;
      hot_ff <= 1'b0;
    end else begin
      en_s1_ff <= EN_PIN;
      en_s2_ff <= en_s1_ff;
      en_s3_ff <= en_s2_ff;
      if (en_s2_ff == en_s3_ff) begin
        en_ff <= en_s3_ff;
      end
      por_s1_ff <= POR_ACTIVE;
      por_s2_ff <= por_s1_ff;
      por_s3_ff <= por_s2_ff;
      if (por_s2_ff == por_s3_ff) begin
        por_ff <= por_s3_ff;
      end
      hot_s1_ff <= THERMAL_SHUTDOWN;
      hot_s2_ff <= hot_s1_ff;
      hot_s3_ff <= hot_s2_ff;
      if (hot_s2_ff == hot_s3_ff) begin
        hot_ff <= hot_s3_ff;
      end
    end
  end

  assign wr_reset = REG_WR && (REG_ADDR == led_sink_pkg::SOFT_RESET_ADDR);
  // Enable low also holds the device in reset
  assign held_rst = por_ff || !en_ff;

  always_ff @(posedge CORE_CLK or posedge RESET) begin
    if (RESET) begin
      soft_rst_ff <= 1'b0;
    end else begin
      soft_rst_ff <= wr_reset;
    end
  end

  // Register file; any order, whole byte per write
  always_ff @(posedge CORE_CLK or posedge RESET) begin
    if (RESET) begin
      config_ff <= led_sink_pkg::CONFIG_RESET;
      psave_ff <= led_sink_pkg::POWER_SAVE_RESET;
    end else if (soft_rst_ff || held_rst) begin
      config_ff <= led_sink_pkg::CONFIG_RESET;
      psave_ff <= led_sink_pkg::POWER_SAVE_RESET;
    end else if (REG_WR) begin
      if (REG_ADDR == led_sink_pkg::CHIP_CONFIG_ADDR) begin
        config_ff <= REG_WDATA;
      end
      if (REG_ADDR == led_sink_pkg::POWER_SAVE_ADDR) begin
        psave_ff <= REG_WDATA;
      end
    end
  end

  genvar g;
  generate
    for (g = 0; g < led_sink_pkg::NUM_CH; g++) begin : g_ch
      localparam logic [7:0] CA = led_sink_pkg::CTRL_BASE_ADDR + 8'(g);
      localparam logic [7:0] BA = led_sink_pkg::BRIGHT_BASE_ADDR + 8'(g);
      logic [7:0] src;
      logic [11:0] lin12, log12, code12;
      logic [11:0] lt;
      logic [8:0] man;
      logic blocked;

      always_ff @(posedge CORE_CLK or posedge RESET) begin
        if (RESET) begin
          ctrl_ff[g] <= led_sink_pkg::CTRL_RESET;
          bright_ff[g] <= led_sink_pkg::BRIGHT_RESET;
        end else if (soft_rst_ff || held_rst) begin
          ctrl_ff[g] <= led_sink_pkg::CTRL_RESET;
          bright_ff[g] <= led_sink_pkg::BRIGHT_RESET;
        end else if (REG_WR) begin
          if (REG_ADDR == CA) begin
            ctrl_ff[g] <= REG_WDATA;
          end
          if (REG_ADDR == BA) begin
            bright_ff[g] <= REG_WDATA;
          end
        end
      end

      // Engine value wins over direct register
      assign src = ENGINE_ACTIVE[g] ? ENGINE_BRIGHT[g*8 +: 8] :
                   bright_ff[g];
      // Linear: code/255 scaled into 12 bits (code*4095/255 = code*16+code/16)
      assign lin12 = {src, 4'h0} | {8'h00, src[7:4]};
      // Log: code*12/256 as octave and fraction, spans 1 to ~4000
      assign lt = 12'(src) * 12'h00c;
      assign man = {1'b1, lt[7:0]};
      assign log12 = (src == 8'h00) ? 12'h000 :
                     12'((20'(man) << lt[11:8]) >> 8);
      assign code12 = ctrl_ff[g][led_sink_pkg::CURVE_BIT] ? log12 :
                      lin12;
      if (g == led_sink_pkg::NUM_CH - 1) begin : g_als
        assign blocked = config_ff[led_sink_pkg::LIGHT_IN_BIT];
      end else begin : g_norm
        assign blocked = 1'b0;
      end

      always_ff @(posedge CORE_CLK or posedge RESET) begin
        if (RESET) begin
          SINK_ON[g] <= 1'b0;
          SINK_CODE[g*12 +: 12] <= 12'h000;
          SUPPLY_EXT[g] <= 1'b0;
          RANGE_SEL[g*2 +: 2] <= 2'h0;
        end else begin
          // Sinks only in normal or power-save, never in soft start
          SINK_ON[g] <= ((mode_ff == led_sink_pkg::ST_NORMAL) ||
                         (mode_ff == led_sink_pkg::ST_POWERSAVE)) &&
                        !blocked && (code12 != 12'h000);
          SINK_CODE[g*12 +: 12] <= code12;
          SUPPLY_EXT[g] <= ctrl_ff[g][led_sink_pkg::SUPPLY_BIT];
          RANGE_SEL[g*2 +: 2] <=
            ctrl_ff[g][led_sink_pkg::RANGE_LSB +: 2];
        end
      end
    end
  endgenerate

  // Mode sequencer
  always_comb begin
    nxt_mode = mode_ff;
    nxt_cnt = (cnt_ff == '0) ? cnt_ff : cnt_ff - CW'(1);
    case (mode_ff)
      led_sink_pkg::ST_RESET: begin
        if (!por_ff) begin
          nxt_mode = led_sink_pkg::ST_STANDBY;
        end
      end
      led_sink_pkg::ST_STANDBY: begin
        if (en_ff) begin
          nxt_mode = led_sink_pkg::ST_MEMINIT;
          nxt_cnt = CW'(MEM_INIT_CYC);
        end
      end
      led_sink_pkg::ST_MEMINIT: begin
        if (cnt_ff == '0 && config_ff[led_sink_pkg::CHIP_RUN_BIT]) begin
          nxt_mode = led_sink_pkg::ST_STARTUP;
          nxt_cnt = CW'(STARTUP_CYC);
        end
      end
      led_sink_pkg::ST_STARTUP: begin
        if (hot_ff) begin
          nxt_cnt = CW'(STARTUP_CYC);
        end else if (cnt_ff == '0) begin
          if (config_ff[led_sink_pkg::BOOST_EN_BIT]) begin
            nxt_mode = led_sink_pkg::ST_BOOST;
            nxt_cnt = CW'(SOFT_START_CYC);
          end else begin
            nxt_mode = led_sink_pkg::ST_NORMAL;
          end
        end
      end
      led_sink_pkg::ST_BOOST: begin
        if (cnt_ff == '0) begin
          nxt_mode = led_sink_pkg::ST_NORMAL;
        end
      end
      led_sink_pkg::ST_NORMAL: begin
        if (!BOOST_ON && config_ff[led_sink_pkg::BOOST_EN_BIT]) begin
          nxt_mode = led_sink_pkg::ST_BOOST;
          nxt_cnt = CW'(SOFT_START_CYC);
        end else if (psave_ff[led_sink_pkg::POWER_SAVE_BIT]) begin
          nxt_mode = led_sink_pkg::ST_POWERSAVE;
        end
      end
      led_sink_pkg::ST_POWERSAVE: begin
        if (!psave_ff[led_sink_pkg::POWER_SAVE_BIT]) begin
          nxt_mode = led_sink_pkg::ST_NORMAL;
        end
      end
      default: begin
        nxt_mode = led_sink_pkg::ST_RESET;
      end
    endcase
    // Leaving run or overheating returns to lower modes
    if ((mode_ff == led_sink_pkg::ST_BOOST ||
         mode_ff == led_sink_pkg::ST_NORMAL ||
         mode_ff == led_sink_pkg::ST_POWERSAVE) && hot_ff) begin
      nxt_mode = led_sink_pkg::ST_STARTUP;
      nxt_cnt = CW'(STARTUP_CYC);
    end
    if (mode_ff != led_sink_pkg::ST_RESET &&
        mode_ff != led_sink_pkg::ST_STANDBY &&
        mode_ff != led_sink_pkg::ST_MEMINIT &&
        !config_ff[led_sink_pkg::CHIP_RUN_BIT]) begin
      nxt_mode = led_sink_pkg::ST_MEMINIT;
      nxt_cnt = '0;
    end
    if (soft_rst_ff || held_rst) begin
      nxt_mode = led_sink_pkg::ST_RESET;
      nxt_cnt = '0;
    end
  end

  always_ff @(posedge CORE_CLK or posedge RESET) begin
    if (RESET) begin
      mode_ff <= led_sink_pkg::ST_RESET;
      cnt_ff <= '0;
    end else begin
      mode_ff <= nxt_mode;
      cnt_ff <= nxt_cnt;
    end
  end

  // Analogue and status outputs
  always_ff @(posedge CORE_CLK or posedge RESET) begin
    if (RESET) begin
      BOOST_ON <= 1'b0;
      ANALOG_ON <= 1'b0;
      POWER_SAVE_ON <= 1'b0;
      MEM_INIT_BUSY <= 1'b0;
      MODE <= 3'h0;
    end else begin
      // Boost follows its enable bit in boost, normal and power-save modes, not supply selection
      BOOST_ON <= (nxt_mode == led_sink_pkg::ST_BOOST ||
                   nxt_mode == led_sink_pkg::ST_NORMAL ||
                   nxt_mode == led_sink_pkg::ST_POWERSAVE) &&
                  config_ff[led_sink_pkg::BOOST_EN_BIT];
      ANALOG_ON <= (mode_ff == led_sink_pkg::ST_STARTUP && !hot_ff) ||
                   mode_ff == led_sink_pkg::ST_BOOST ||
                   mode_ff == led_sink_pkg::ST_NORMAL ||
                   (mode_ff == led_sink_pkg::ST_POWERSAVE &&
                    !DEVICE_IDLE);
      POWER_SAVE_ON <= mode_ff == led_sink_pkg::ST_POWERSAVE && DEVICE_IDLE;
      MEM_INIT_BUSY <= mode_ff == led_sink_pkg::ST_MEMINIT &&
                       cnt_ff != '0;
      MODE <= mode_ff;
    end
  end

  // Read data; reset register reads as zero
  always_ff @(posedge CORE_CLK or posedge RESET) begin
    if (RESET) begin
      REG_RDATA <= 8'h00;
    end else if (REG_RD) begin
      REG_RDATA <= 8'h00;
      if (REG_ADDR == led_sink_pkg::CHIP_CONFIG_ADDR) begin
        REG_RDATA <= config_ff;
      end
      if (REG_ADDR == led_sink_pkg::POWER_SAVE_ADDR) begin
        REG_RDATA <= psave_ff;
      end
      for (int i = 0; i < led_sink_pkg::NUM_CH; i++) begin
        if (REG_ADDR == led_sink_pkg::CTRL_BASE_ADDR + 8'(i)) begin
          REG_RDATA <= ctrl_ff[i];
        end
        if (REG_ADDR == led_sink_pkg::BRIGHT_BASE_ADDR + 8'(i)) begin
          REG_RDATA <= bright_ff[i];
        end
      end
    end
  end
endmodule
`default_nettype wire

// File: tb/led_sink_checker.sv
`timescale 1ns/1ps
`default_nettype none
module led_sink_checker (
  // Clock and reset
  input wire logic CORE_CLK,
  input wire logic RESET,
  // Watched inputs
  input wire logic EN_PIN,
  input wire logic POR_ACTIVE,
  input wire logic THERMAL_SHUTDOWN,
  input wire logic REG_WR,
  input wire logic [7:0] REG_ADDR,
  input wire logic [7:0] REG_WDATA,
  // Watched outputs
  input wire logic BOOST_ON,
  input wire logic [2:0] MODE,
  input wire logic [9:0] SINK_ON,
  input wire logic [9:0] SUPPLY_EXT,
  input wire logic [19:0] RANGE_SEL
);
  default clocking cb @(posedge CORE_CLK); endclocking
  default disable iff (RESET);
  AST_POR_HOLD: assert property (
    POR_ACTIVE [*6] |-> MODE == 3'h0)
    else $error("mode left reset while power-on reset active");
  AST_EN_LOW: assert property (
    !EN_PIN [*7] |-> MODE == 3'h0)
    else $error("mode left reset while enable low");
  AST_SOFT_RESET: assert property (
    REG_WR && MODE != 3'h0 && REG_ADDR == led_sink_pkg::SOFT_RESET_ADDR
    |-> ##[1:4] MODE == 3'h0)
    else $error("soft reset write did not reach reset mode");
  AST_SOFTSTART_DARK: assert property (
    MODE == 3'h4 |-> SINK_ON == 10'h000)
    else $error("sink on during boost soft start");
  AST_IDLE_DARK: assert property (
    MODE inside {3'h0, 3'h1, 3'h2, 3'h3} |-> SINK_ON == 10'h000)
    else $error("sink on outside run modes");
  AST_THERMAL: assert property (
    THERMAL_SHUTDOWN [*7] |-> !(MODE inside {3'h4, 3'h5, 3'h6}))
    else $error("run mode kept during thermal shutdown");
  AST_BOOST_UP: assert property (
    $rose(MODE == 3'h4) |-> ##[0:2] BOOST_ON)
    else $error("boost off in soft start");
  AST_CTRL_EFFECT: assert property (
    REG_WR && MODE == 3'h5 && REG_ADDR == led_sink_pkg::CTRL_BASE_ADDR
    |-> ##2 {SUPPLY_EXT[0], RANGE_SEL[1:0]} ==
    {$past(REG_WDATA[6], 2), $past(REG_WDATA[4:3], 2)})
    else $error("control write not reflected");
  AST_STANDBY_QUIET: assert property (
    MODE inside {3'h0, 3'h1} && $past(MODE) inside {3'h0, 3'h1}
    |-> !BOOST_ON)
    else $error("boost on in reset or standby");
  COV_SOFTSTART: cover property ($rose(MODE == 3'h4));
  COV_POWERSAVE: cover property ($rose(MODE == 3'h6));
  COV_THERMAL: cover property (THERMAL_SHUTDOWN ##[1:20] MODE == 3'h3);
endmodule
bind led_sink_mode_control led_sink_checker chk_i (.CORE_CLK(CORE_CLK),
  .RESET(RESET), .EN_PIN(EN_PIN), .POR_ACTIVE(POR_ACTIVE),
  .THERMAL_SHUTDOWN(THERMAL_SHUTDOWN), .REG_WR(REG_WR),
  .REG_ADDR(REG_ADDR), .REG_WDATA(REG_WDATA), .BOOST_ON(BOOST_ON),
  .MODE(MODE), .SINK_ON(SINK_ON), .SUPPLY_EXT(SUPPLY_EXT),
  .RANGE_SEL(RANGE_SEL));
`default_nettype wire

// File: tb/host_model.sv
`timescale 1ns/1ps
`default_nettype none
module host_model (
  // Clock
  input wire logic clk,
  // Register port
  output logic wr,
  output logic rd,
  output logic [7:0] addr,
  output logic [7:0] wdata,
  input wire logic [7:0] rdata
);
  initial begin
    wr = 1'b0;
    rd = 1'b0;
    addr = 8'h00;
    wdata = 8'h00;
  end
  task automatic write_reg(input logic [7:0] a, input logic [7:0] d);
    @(posedge clk);
    wr <= 1'b1;
    addr <= a;
    wdata <= d;
    @(posedge clk);
    wr <= 1'b0;
    wdata <= ~d;
  endtask
  task automatic read_reg(input logic [7:0] a, output logic [7:0] d);
    @(posedge clk);
    rd <= 1'b1;
    addr <= a;
    @(posedge clk);
    rd <= 1'b0;
    @(posedge clk);
    #1 d = rdata;
  endtask
endmodule
`default_nettype wire

// File: tb/testbench.sv
`timescale 1ns/1ps
`default_nettype none
module testbench;
  logic clk, rst, en, por, hot, idle, wr, rd;
  logic boost, analog, psave, mbusy;
  logic [7:0] addr, wdata, rdata, rv;
  logic [9:0] eng_act, sink, sup;
  logic [79:0] eng_br;
  logic [2:0] mode;
  logic [19:0] rng;
  logic [119:0] code;
  logic [7:0] wa [8] = '{8'h06, 8'h16, 8'h07, 8'h17,
                         8'h08, 8'h18, 8'h0f, 8'h1f};
  logic [7:0] wd [8] = '{8'h58, 8'hff, 8'h20, 8'h01,
                         8'h00, 8'h33, 8'h00, 8'hff};
  int fails, check_count;
  led_sink_mode_control #(.MEM_INIT_CYC(4), .STARTUP_CYC(4),
    .SOFT_START_CYC(4)) DUT (.CORE_CLK(clk), .RESET(rst), .EN_PIN(en),
    .POR_ACTIVE(por), .THERMAL_SHUTDOWN(hot), .DEVICE_IDLE(idle),
    .REG_WR(wr), .REG_RD(rd), .REG_ADDR(addr), .REG_WDATA(wdata),
    .REG_RDATA(rdata), .ENGINE_ACTIVE(eng_act), .ENGINE_BRIGHT(eng_br),
    .BOOST_ON(boost), .ANALOG_ON(analog), .POWER_SAVE_ON(psave),
    .MEM_INIT_BUSY(mbusy), .MODE(mode), .SINK_ON(sink), .SUPPLY_EXT(sup),
    .RANGE_SEL(rng), .SINK_CODE(code));
  host_model host (.clk(clk), .wr(wr), .rd(rd), .addr(addr),
    .wdata(wdata), .rdata(rdata));
  initial begin
    clk = 1'b0;
    forever #5 clk = ~clk;
  end
  task automatic results;
    $display("checks %0d mismatches %0d", check_count, fails);
    if (fails == 0 && check_count > 0) $display("NO MISMATCHES");
    else $display("MISMATCHES SEEN");
    $finish;
  endtask
  task automatic chk(input string n, input logic [11:0] e,
                     input logic [11:0] g);
    check_count++;
    if (g !== e) begin
      fails++;
      $display("wrong value %s expected %h seen %h", n, e, g);
    end
  endtask
  task automatic wait_mode(input logic [2:0] m);
    for (int i = 0; i < 300 && mode !== m; i++) begin
      @(posedge clk);
      #1;
    end
    chk("mode", 12'(m), 12'(mode));
    if (mode !== m) results();
  endtask
  function automatic logic [11:0] cc(input int ch);
    return code[ch*12 +: 12];
  endfunction
  initial begin
    {rst, en, por, hot, idle} = 5'b11100;
    eng_act = 10'h000;
    eng_br = 80'h0;
    fails = 0;
    check_count = 0;
    repeat (16) @(posedge clk);
    rst <= 1'b0;
    repeat (8) @(posedge clk);
    #1 chk("por hold", 12'h0, 12'(mode));
    @(posedge clk) por <= 1'b0;
    wait_mode(3'h2);
    @(posedge clk);
    #1 chk("mem init", 12'h1, 12'(mbusy));
    host.read_reg(led_sink_pkg::CHIP_CONFIG_ADDR, rv);
    chk("run bit", 12'h0, 12'(rv[6]));
    for (int i = 0; i < 8; i++) host.write_reg(wa[i], wd[i]);
    host.write_reg(led_sink_pkg::CHIP_CONFIG_ADDR, 8'h40);
    wait_mode(3'h3);
    wait_mode(3'h5);
    chk("boost", 12'h0, 12'(boost));
    chk("analog", 12'h1, 12'(analog));
    chk("supply", 12'h1, 12'(sup[1:0]));
    chk("range", 12'h3, 12'(rng[3:0]));
    chk("code1", 12'hfff, cc(0));
    chk("code3", 12'h333, cc(2));
    chk("log", 12'h1, cc(1));
    chk("sinks", 12'h207, 12'(sink));
    host.read_reg(8'h06, rv);
    chk("ctrl read", 12'h58, 12'(rv));
    host.write_reg(8'h06, 8'h50);
    repeat (3) @(posedge clk);
    #1 chk("range new", 12'h2, 12'(rng[1:0]));
    host.write_reg(led_sink_pkg::CHIP_CONFIG_ADDR, 8'h41);
    wait_mode(3'h4);
    chk("soft start", 12'h0, 12'(sink));
    wait_mode(3'h5);
    @(posedge clk) eng_act <= 10'h006;
    eng_br <= (80'hff << 16) | (80'hff << 8);
    repeat (4) @(posedge clk);
    #1 chk("engine", 12'hfff, cc(2));
    chk("log top", 12'h1, 12'(cc(1) >= 12'hf80));
    host.write_reg(led_sink_pkg::CHIP_CONFIG_ADDR, 8'h43);
    repeat (12) @(posedge clk);
    wait_mode(3'h5);
    chk("light input", 12'h0, 12'(sink[9]));
    @(posedge clk) hot <= 1'b1;
    wait_mode(3'h3);
    repeat (10) @(posedge clk);
    #1 chk("thermal", 12'h3, 12'(mode));
    chk("thermal off", 12'h0, 12'(analog));
    @(posedge clk) hot <= 1'b0;
    wait_mode(3'h5);
    host.write_reg(led_sink_pkg::POWER_SAVE_ADDR, 8'h20);
    @(posedge clk) idle <= 1'b1;
    wait_mode(3'h6);
    chk("power save", 12'h1, 12'(psave));
    chk("analog idle", 12'h0, 12'(analog));
    @(posedge clk) idle <= 1'b0;
    host.write_reg(led_sink_pkg::POWER_SAVE_ADDR, 8'h00);
    wait_mode(3'h5);
    host.write_reg(led_sink_pkg::SOFT_RESET_ADDR, 8'h5a);
    wait_mode(3'h0);
    wait_mode(3'h2);
    host.read_reg(8'h06, rv);
    chk("ctrl default", 12'h0, 12'(rv));
    host.read_reg(led_sink_pkg::CHIP_CONFIG_ADDR, rv);
    chk("config default", 12'h0, 12'(rv));
    @(posedge clk) en <= 1'b0;
    wait_mode(3'h0);
    repeat (10) @(posedge clk);
    #1 chk("enable low", 12'h0, 12'(mode));
    @(posedge clk) en <= 1'b1;
    wait_mode(3'h2);
    results();
  end
endmodule
`default_nettype wire
